// *** design/gla_top.sv ***
// gated latch array top: synchronised controls and the bit store
`timescale 1ns/10ps
`include "gla_defines.svh"
module gla_top #(
	parameter int                    WIDTH   = `GLA_WIDTH_DEF,
	parameter gla_pkg::gla_variant_e VARIANT = gla_pkg::GLA_DATA
) (
	input  wire logic             mclk_i,
	input  wire logic             srst_i,
	input  wire logic             gate_i,
	input  wire logic             force_one_n_i,
	input  wire logic             force_zero_n_i,
	input  wire logic [WIDTH-1:0] set_i,
	input  wire logic [WIDTH-1:0] reset_i,
	input  wire logic [WIDTH-1:0] data_i,
	output logic      [WIDTH-1:0] q_o,
	output logic      [WIDTH-1:0] qb_o
);
	import gla_pkg::*;

	// gate synchroniser
	logic             gate_meta_ff;
	logic             gate_sync_ff;
	logic             nxt_gate_meta;
	logic             nxt_gate_sync;

	// force-one synchroniser
	logic             one_n_meta_ff;
	logic             one_n_sync_ff;
	logic             nxt_one_n_meta;
	logic             nxt_one_n_sync;

	// force-zero synchroniser
	logic             zero_n_meta_ff;
	logic             zero_n_sync_ff;
	logic             nxt_zero_n_meta;
	logic             nxt_zero_n_sync;

	// set synchroniser, read only by the set/reset variant
	logic [WIDTH-1:0] set_meta_ff;
	logic [WIDTH-1:0] set_sync_ff;
	logic [WIDTH-1:0] nxt_set_meta;
	logic [WIDTH-1:0] nxt_set_sync;

	// reset synchroniser, read only by the set/reset variant
	logic [WIDTH-1:0] reset_meta_ff;
	logic [WIDTH-1:0] reset_sync_ff;
	logic [WIDTH-1:0] nxt_reset_meta;
	logic [WIDTH-1:0] nxt_reset_sync;

	// data synchroniser, read only by the data variant
	logic [WIDTH-1:0] data_meta_ff;
	logic [WIDTH-1:0] data_sync_ff;
	logic [WIDTH-1:0] nxt_data_meta;
	logic [WIDTH-1:0] nxt_data_sync;

	// shared control towards the bit store
	gla_act_e         act;
	gla_ctrl_if       ctrl ();

	// control decode: both forces low > force-zero > force-one > gate
	function automatic gla_act_e decode_act(
		input logic gate,
		input logic one_n,
		input logic zero_n
	);
		logic     zero_on;
		logic     one_on;
		gla_act_e res;

		zero_on = !zero_n; // pins are active low
		one_on  = !one_n;
		if (zero_on && one_on) begin
			res = GLA_ACT_BOTH;
		end else if (zero_on) begin
			res = GLA_ACT_ZERO;
		end else if (one_on) begin
			res = GLA_ACT_ONE;
		end else if (gate) begin
			res = GLA_ACT_LOAD;
		end else begin
			res = GLA_ACT_HOLD;
		end
		return res;
	endfunction : decode_act

	// gate synchroniser next values
	always_comb begin
		nxt_gate_meta = gate_i;
		nxt_gate_sync = gate_meta_ff;
	end

	// gate stages; reset low so the array holds until a gate is seen
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			gate_meta_ff <= `GLA_GATE_RST;
			gate_sync_ff <= `GLA_GATE_RST;
		end else begin
			gate_meta_ff <= nxt_gate_meta;
			gate_sync_ff <= nxt_gate_sync;
		end
	end

	// force-one synchroniser next values
	always_comb begin
		nxt_one_n_meta = force_one_n_i;
		nxt_one_n_sync = one_n_meta_ff;
	end

	// force-one stages; reset inactive so no false force follows reset
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			one_n_meta_ff <= `GLA_FORCE_N_RST;
			one_n_sync_ff <= `GLA_FORCE_N_RST;
		end else begin
			one_n_meta_ff <= nxt_one_n_meta;
			one_n_sync_ff <= nxt_one_n_sync;
		end
	end

	// force-zero synchroniser next values
	always_comb begin
		nxt_zero_n_meta = force_zero_n_i;
		nxt_zero_n_sync = zero_n_meta_ff;
	end

	// force-zero stages; reset inactive like force-one
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			zero_n_meta_ff <= `GLA_FORCE_N_RST;
			zero_n_sync_ff <= `GLA_FORCE_N_RST;
		end else begin
			zero_n_meta_ff <= nxt_zero_n_meta;
			zero_n_sync_ff <= nxt_zero_n_sync;
		end
	end

	// set synchroniser next values, bit i feeds bit i only
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			nxt_set_meta[i] = set_i[i];
			nxt_set_sync[i] = set_meta_ff[i];
		end
	end

	// set stages; bits are not aligned to each other, a skewed change may land split
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			set_meta_ff <= {WIDTH{`GLA_BIT_RST}};
			set_sync_ff <= {WIDTH{`GLA_BIT_RST}};
		end else begin
			set_meta_ff <= nxt_set_meta;
			set_sync_ff <= nxt_set_sync;
		end
	end

	// reset synchroniser next values, bit i feeds bit i only
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			nxt_reset_meta[i] = reset_i[i];
			nxt_reset_sync[i] = reset_meta_ff[i];
		end
	end

	// reset stages
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			reset_meta_ff <= {WIDTH{`GLA_BIT_RST}};
			reset_sync_ff <= {WIDTH{`GLA_BIT_RST}};
		end else begin
			reset_meta_ff <= nxt_reset_meta;
			reset_sync_ff <= nxt_reset_sync;
		end
	end

	// data synchroniser next values, bit i feeds bit i only
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			nxt_data_meta[i] = data_i[i];
			nxt_data_sync[i] = data_meta_ff[i];
		end
	end

	// data stages; same latency as the controls so gate and data stay aligned
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			data_meta_ff <= {WIDTH{`GLA_BIT_RST}};
			data_sync_ff <= {WIDTH{`GLA_BIT_RST}};
		end else begin
			data_meta_ff <= nxt_data_meta;
			data_sync_ff <= nxt_data_sync;
		end
	end

	// one decode for the whole array, so every bit is forced or gated together
	always_comb begin
		act = decode_act(gate_sync_ff, one_n_sync_ff, zero_n_sync_ff);
	end

	// hand the action to the bit store through the control bundle
	assign ctrl.act = act;

	// bit store; its flops drive the outputs directly
	gla_bits #(
		.WIDTH   (WIDTH),
		.VARIANT (VARIANT)
	) u_bits (
		.mclk_i  (mclk_i),
		.srst_i  (srst_i),
		.ctrl    (ctrl.dst),
		.set_i   (set_sync_ff),
		.reset_i (reset_sync_ff),
		.data_i  (data_sync_ff),
		.q_o     (q_o),
		.qb_o    (qb_o)
	);

endmodule : gla_top

// *** design/gla_defines.svh ***
// constants for the gated latch array
`ifndef GLA_DEFINES_SVH
`define GLA_DEFINES_SVH
`define GLA_WIDTH_DEF 8
`define GLA_Q_RST     1'h0
`define GLA_QB_RST    1'h1
`define GLA_GATE_RST    1'h0
`define GLA_FORCE_N_RST 1'h1
`define GLA_BIT_RST     1'h0
`endif

// *** design/gla_pkg.sv ***
// types shared by the gated latch array files
package gla_pkg;
	typedef enum logic {
		GLA_SET_RESET,
		GLA_DATA
	} gla_variant_e;
	// control decode outcome for one cycle
	typedef enum logic [2:0] {
		GLA_ACT_HOLD,
		GLA_ACT_ZERO,
		GLA_ACT_ONE,
		GLA_ACT_BOTH,
		GLA_ACT_LOAD
	} gla_act_e;
endpackage : gla_pkg

// *** design/gla_ctrl_if.sv ***
// shared control bundle between the top and the bit array
`timescale 1ns/10ps
interface gla_ctrl_if;
	import gla_pkg::*;
	gla_act_e act;
	modport src (output act);
	modport dst (input act);
endinterface : gla_ctrl_if

// *** design/gla_bits.sv ***
// per-bit storage of the gated latch array
`timescale 1ns/10ps
`include "gla_defines.svh"
module gla_bits #(
	parameter int                   WIDTH   = `GLA_WIDTH_DEF,
	parameter gla_pkg::gla_variant_e VARIANT = gla_pkg::GLA_DATA
) (
	input  wire logic             mclk_i,
	input  wire logic             srst_i,
	gla_ctrl_if.dst               ctrl,
	input  wire logic [WIDTH-1:0] set_i,
	input  wire logic [WIDTH-1:0] reset_i,
	input  wire logic [WIDTH-1:0] data_i,
	output logic      [WIDTH-1:0] q_o,
	output logic      [WIDTH-1:0] qb_o
);
	import gla_pkg::*;
	logic [WIDTH-1:0] q_ff;
	logic [WIDTH-1:0] qb_ff;
	logic [WIDTH-1:0] nxt_q;
	logic [WIDTH-1:0] nxt_qb;

	// next value per bit; q and qb kept separately so both-high can be shown
	always_comb begin
		nxt_q  = q_ff;
		nxt_qb = qb_ff;
		for (int i = 0; i < WIDTH; i++) begin
			unique case (ctrl.act)
				GLA_ACT_ZERO: begin
					nxt_q[i]  = 1'h0;
					nxt_qb[i] = 1'h1;
				end
				GLA_ACT_ONE: begin
					nxt_q[i]  = 1'h1;
					nxt_qb[i] = 1'h0;
				end
				GLA_ACT_BOTH: begin
					nxt_q[i]  = 1'h1;
					nxt_qb[i] = 1'h1;
				end
				GLA_ACT_LOAD: begin
					if (VARIANT == GLA_DATA) begin
						nxt_q[i]  = data_i[i];
						nxt_qb[i] = ~data_i[i];
					end else if (set_i[i] || reset_i[i]) begin
						// both high gives both outputs high; treat that state as undefined downstream
						nxt_q[i]  = set_i[i];
						nxt_qb[i] = reset_i[i];
					end
				end
				GLA_ACT_HOLD: begin
					nxt_q[i]  = q_ff[i];
					nxt_qb[i] = qb_ff[i];
				end
			endcase
		end
	end

	// registered state
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			q_ff  <= {WIDTH{`GLA_Q_RST}};
			qb_ff <= {WIDTH{`GLA_QB_RST}};
		end else begin
			q_ff  <= nxt_q;
			qb_ff <= nxt_qb;
		end
	end

	assign q_o  = q_ff;
	assign qb_o = qb_ff;
endmodule : gla_bits

// *** sim/gla_env.sv ***
// partner model: surrounding logic driving gate, forces and bit inputs
`timescale 1ns/10ps
module gla_env (
	input  wire logic        mclk_i,
	input  wire logic [10:0] req_i,
	output logic      [10:0] pins_o = 11'h300
);
	// launch on the falling edge, clear of the sampling edge; one gate and force pair for all bits
	always @(negedge mclk_i) pins_o <= req_i;
endmodule : gla_env

// *** sim/gla_chk_assertions.sv ***
// output checks for the gated latch array
`timescale 1ns/10ps
`include "gla_defines.svh"
module gla_chk #(
	parameter int                    WIDTH   = `GLA_WIDTH_DEF,
	parameter gla_pkg::gla_variant_e VARIANT = gla_pkg::GLA_DATA
) (
	input wire logic             mclk_i,
	input wire logic             srst_i,
	input wire logic             gate_i,
	input wire logic             force_one_n_i,
	input wire logic             force_zero_n_i,
	input wire logic [WIDTH-1:0] set_i,
	input wire logic [WIDTH-1:0] reset_i,
	input wire logic [WIDTH-1:0] data_i,
	input wire logic [WIDTH-1:0] q_o,
	input wire logic [WIDTH-1:0] qb_o
);
	import gla_pkg::*;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	// open gate with no force; every control shows three edges after it is sampled
	wire run = gate_i & force_one_n_i & force_zero_n_i;
	chk_zero_force: assert property (!force_zero_n_i && force_one_n_i |-> ##3 q_o == '0 && qb_o == '1)
		else $error("zero force");
	chk_one_force: assert property (force_zero_n_i && !force_one_n_i |-> ##3 q_o == '1 && qb_o == '0)
		else $error("one force");
	chk_both_force: assert property (!force_zero_n_i && !force_one_n_i |-> ##3 q_o == '1 && qb_o == '1)
		else $error("both force");
	chk_sr_next: assert property (VARIANT == GLA_SET_RESET && run |-> ##3
		q_o == ($past(set_i, 3) | $past(q_o) & ~$past(reset_i, 3)) && qb_o == ($past(reset_i, 3) | $past(qb_o) & ~$past(set_i, 3)))
		else $error("sr step");
	chk_data_follow: assert property (VARIANT == GLA_DATA && run |-> ##3
		q_o == $past(data_i, 3) && qb_o == ~$past(data_i, 3)) else $error("data follow");
	chk_gate_hold: assert property (!gate_i && force_one_n_i && force_zero_n_i |-> ##3
		$stable(q_o) && $stable(qb_o)) else $error("gate hold");
endmodule : gla_chk
bind gla_top gla_chk #(.WIDTH(WIDTH), .VARIANT(VARIANT)) u_chk (.mclk_i(mclk_i), .srst_i(srst_i), .gate_i(gate_i),
	.force_one_n_i(force_one_n_i), .force_zero_n_i(force_zero_n_i), .set_i(set_i), .reset_i(reset_i),
	.data_i(data_i), .q_o(q_o), .qb_o(qb_o));

// *** sim/testbench.sv ***
// self-checking bench: set/reset and data variants side by side
`timescale 1ns/10ps
module testbench;
	import gla_pkg::*;
	logic        mclk_i = 1'h0;
	logic        srst_i = 1'h1;
	logic [10:0] req = 11'h300;
	logic [10:0] pins;
	logic [3:0]  q_sr, qb_sr, q_d, qb_d;
	int          num_errors = 0;
	int          checked = 0;
	gla_env env (.mclk_i(mclk_i), .req_i(req), .pins_o(pins));
	// both variants share one set of pins; each ignores what it does not use
	gla_top #(.WIDTH(4), .VARIANT(GLA_SET_RESET)) uut (.mclk_i(mclk_i), .srst_i(srst_i), .gate_i(pins[10]),
		.force_one_n_i(pins[9]), .force_zero_n_i(pins[8]), .set_i(pins[7:4]), .reset_i(pins[3:0]),
		.data_i(pins[7:4]), .q_o(q_sr), .qb_o(qb_sr));
	gla_top #(.WIDTH(4), .VARIANT(GLA_DATA)) uut_d (.mclk_i(mclk_i), .srst_i(srst_i), .gate_i(pins[10]),
		.force_one_n_i(pins[9]), .force_zero_n_i(pins[8]), .set_i(pins[7:4]), .reset_i(pins[3:0]),
		.data_i(pins[7:4]), .q_o(q_d), .qb_o(qb_d));
	// clock
	initial forever #2 mclk_i = ~mclk_i;
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask : chk
	// request {gate, force_one_n, force_zero_n, set/data, reset}; wait out launch plus latency
	task st(input logic [10:0] v, input logic [7:0] e_sr, input logic [7:0] e_d);
		@(posedge mclk_i) req <= v;
		repeat (5) @(posedge mclk_i);
		#1;
		chk({q_sr, qb_sr}, e_sr);
		chk({q_d, qb_d}, e_d);
	endtask : st
	task force_test;
		st(11'h600, 8'h0F, 8'h0F);
		st(11'h500, 8'hF0, 8'hF0);
		st(11'h400, 8'hFF, 8'hFF);
	endtask : force_test
	task gate_test;
		st(11'h7A5, 8'hA5, 8'hA5);
		st(11'h700, 8'hA5, 8'h0F);
		st(11'h7CC, 8'hED, 8'hC3);
	endtask : gate_test
	task hold_test;
		st(11'h396, 8'hED, 8'hC3);
		st(11'h70F, 8'h0F, 8'h0F);
	endtask : hold_test
	// mid-run reset from a loaded state; gate stays low after release, so the reset value must hold
	task reset_test;
		st(11'h7A5, 8'hA5, 8'hA5);
		@(negedge mclk_i) srst_i = 1'h1;
		req <= 11'h396;
		repeat (3) @(negedge mclk_i);
		srst_i = 1'h0;
		repeat (6) @(posedge mclk_i);
		#1;
		chk({q_sr, qb_sr}, 8'h0F);
		chk({q_d, qb_d}, 8'h0F);
	endtask : reset_test
	task close_out;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out
	// main sequence
	initial begin
		repeat (12) @(negedge mclk_i);
		srst_i = 1'h0;
		force_test();
		gate_test();
		hold_test();
		reset_test();
		close_out();
	end
	// watchdog, about four times the expected run
	initial begin
		#1300;
		num_errors++;
		close_out();
	end
endmodule : testbench
